// ===== rtl/sees_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - Sample data on rising clock edge, change output after falling edge.
// - Data line is open drain: pull low or release only.
// - Data falling while clock high is start; every transfer begins so.
// - Data rising while clock high is stop; read then goes standby.
// - Stop after write data starts timed programming; standby afterwards.
// - Words are eight bits, MSB first; receiver acks low on ninth clock.
// - Write transfers acknowledge device word, memory address and each byte.
// - After read byte release line; master ack means send next byte.
// - No ack then stop ends the read and returns to standby.
// - Neither ack nor stop: keep line released, send no more data.
// - Address word is type code, select bits A2 A1 A0, direction.
// - Ack only on type and select match, else back to standby.
// - Direction zero writes, direction one reads.
// - Large variant uses lowest select bit as address bit eight.
// - Write protect high blocks all writes; low allows them.
// - Reads work whatever the write-protect level.
// - Byte write is address word, memory address, one byte, stop.
// - During programming all bus activity is ignored.
// - Further bytes accepted; up to eight programmed as one page.
// - Page offset bits increment per byte and wrap within the page.
// - Programming ends within 10 ms, or 15 ms at low supply.
// - No ack to addressing while programming; ack again after.
module sees_slave #(
	parameter logic MEM_512 = 1'b1,
	parameter logic [3:0] DEV_TYPE = sees_pkg::DEV_TYPE_DEFAULT,
	parameter int PROG_CYC_HI = sees_pkg::PROG_CYC_HI,
	parameter int PROG_CYC_LO = sees_pkg::PROG_CYC_LO
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_b_o,
	input wire logic select_pin_0_i,
	input wire logic select_pin_1_i,
	input wire logic select_pin_2_i,
	input wire logic write_protect_i,
	input wire logic [sees_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [sees_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	// ********************************************************
	// Declarations
	// ********************************************************
	localparam int PW = sees_pkg::PROG_CNT_W;
	localparam int AW = sees_pkg::ADDR_W;

	sees_pkg::sees_pins_t pin_raw;
	sees_pkg::sees_pins_t pin_meta_reg;
	sees_pkg::sees_pins_t pin_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	sees_pkg::sees_bus_ev_t ev;

	sees_pkg::sees_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic drive_reg;
	logic rw_reg;
	logic ack_seen_reg;

	logic [AW-1:0] cur_addr_reg;
	logic [AW-1:0] addr_inc;
	logic [7:0] mem [sees_pkg::MEM_WORDS];
	logic [7:0] mem_rd;
	logic [7:0] page_buf [sees_pkg::PAGE_BYTES];
	logic [sees_pkg::PAGE_BYTES-1:0] valid_reg;

	logic [PW-1:0] prog_cnt_reg;
	logic prog_done;
	logic commit;
	logic dev_match;
	logic byte_wr;
	logic maddr_done;
	logic rd_byte_done;

	logic low_supply_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [sees_pkg::AXI_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic wr_fire;
	logic [31:0] status_word;

	// ********************************************************
	// Pin synchronisers and bus events
	// ********************************************************
	assign pin_raw.scl = scl_i;
	assign pin_raw.sda = sda_i;
	assign pin_raw.wp = write_protect_i;
	assign pin_raw.sel = {select_pin_2_i, select_pin_1_i, select_pin_0_i};

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pin_meta_reg <= '1;
			pin_sync_reg <= '1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			scl_prev_reg <= pin_sync_reg.scl;
			sda_prev_reg <= pin_sync_reg.sda;
		end
	end

	// Both lines pass the same delay, so their order is kept
	always_comb begin
		ev.rise = pin_sync_reg.scl & ~scl_prev_reg;
		ev.fall = ~pin_sync_reg.scl & scl_prev_reg;
		ev.start = pin_sync_reg.scl & scl_prev_reg
			& sda_prev_reg & ~pin_sync_reg.sda;
		ev.stop = pin_sync_reg.scl & scl_prev_reg
			& ~sda_prev_reg & pin_sync_reg.sda;
	end

	// ********************************************************
	// Address word decode
	// ********************************************************
	function automatic logic match_word(input logic [7:0] w,
		input logic [2:0] sel, input logic big);
		logic type_ok;
		logic sel_ok;
		type_ok = (w[7:sees_pkg::DEVW_TYPE_LSB] == DEV_TYPE);
		sel_ok = (w[sees_pkg::DEVW_SEL2] == sel[2])
			&& (w[sees_pkg::DEVW_SEL1] == sel[1])
			&& (big || (w[sees_pkg::DEVW_SEL0] == sel[0]));
		return type_ok && sel_ok;
	endfunction

	assign dev_match = match_word(shift_reg, pin_sync_reg.sel, MEM_512);
	assign byte_wr = (state_reg == sees_pkg::ST_WDATA) && ev.fall
		&& (bit_cnt_reg == sees_pkg::BYTE_BITS);
	assign maddr_done = (state_reg == sees_pkg::ST_MADDR) && ev.fall
		&& (bit_cnt_reg == sees_pkg::BYTE_BITS);
	assign rd_byte_done = (state_reg == sees_pkg::ST_RDATA) && ev.fall
		&& (bit_cnt_reg == sees_pkg::LAST_OUT_BIT);
	// WP is looked at the moment the stop arrives
	assign commit = ((state_reg == sees_pkg::ST_WDATA)
		|| (state_reg == sees_pkg::ST_WDATA_ACK))
		&& (|valid_reg) && !pin_sync_reg.wp;
	assign prog_done = (state_reg == sees_pkg::ST_PROG)
		&& (prog_cnt_reg == '0);
	assign mem_rd = mem[cur_addr_reg];

	// ********************************************************
	// Serial state machine
	// ********************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= sees_pkg::ST_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			drive_reg <= 1'b0;
			rw_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else if (state_reg == sees_pkg::ST_PROG) begin
			// Deaf to the bus, so polls go unanswered
			drive_reg <= 1'b0;
			if (prog_done) begin
				state_reg <= sees_pkg::ST_IDLE;
			end
		end else if (ev.stop) begin
			drive_reg <= 1'b0;
			bit_cnt_reg <= '0;
			if (commit) begin
				state_reg <= sees_pkg::ST_PROG;
			end else begin
				state_reg <= sees_pkg::ST_IDLE;
			end
		end else if (ev.start) begin
			drive_reg <= 1'b0;
			bit_cnt_reg <= '0;
			state_reg <= sees_pkg::ST_DEV;
		end else begin
			unique case (state_reg)
				sees_pkg::ST_IDLE, sees_pkg::ST_WAIT: begin
					drive_reg <= 1'b0;
				end
				sees_pkg::ST_DEV, sees_pkg::ST_MADDR,
				sees_pkg::ST_WDATA: begin
					if (ev.rise) begin
						shift_reg <= {shift_reg[6:0], pin_sync_reg.sda};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (ev.fall
						&& bit_cnt_reg == sees_pkg::BYTE_BITS) begin
						bit_cnt_reg <= '0;
						if (state_reg == sees_pkg::ST_DEV) begin
							if (dev_match) begin
								drive_reg <= 1'b1;
								rw_reg <= shift_reg[sees_pkg::DEVW_DIR];
								state_reg <= sees_pkg::ST_DEV_ACK;
							end else begin
								state_reg <= sees_pkg::ST_IDLE;
							end
						end else if (state_reg == sees_pkg::ST_MADDR) begin
							drive_reg <= 1'b1;
							state_reg <= sees_pkg::ST_MADDR_ACK;
						end else begin
							drive_reg <= 1'b1;
							state_reg <= sees_pkg::ST_WDATA_ACK;
						end
					end
				end
				sees_pkg::ST_DEV_ACK: begin
					if (ev.fall) begin
						if (rw_reg == sees_pkg::DIR_READ) begin
							// First bit goes out right after the ninth fall
							shift_reg <= mem_rd;
							drive_reg <= ~mem_rd[7];
							state_reg <= sees_pkg::ST_RDATA;
						end else begin
							drive_reg <= 1'b0;
							state_reg <= sees_pkg::ST_MADDR;
						end
					end
				end
				sees_pkg::ST_MADDR_ACK, sees_pkg::ST_WDATA_ACK: begin
					if (ev.fall) begin
						drive_reg <= 1'b0;
						state_reg <= sees_pkg::ST_WDATA;
					end
				end
				sees_pkg::ST_RDATA: begin
					if (ev.fall) begin
						if (bit_cnt_reg == sees_pkg::LAST_OUT_BIT) begin
							drive_reg <= 1'b0;
							state_reg <= sees_pkg::ST_RACK;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							drive_reg <= ~shift_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				sees_pkg::ST_RACK: begin
					if (ev.rise) begin
						ack_seen_reg <= ~pin_sync_reg.sda;
					end else if (ev.fall) begin
						bit_cnt_reg <= '0;
						if (ack_seen_reg) begin
							shift_reg <= mem_rd;
							drive_reg <= ~mem_rd[7];
							state_reg <= sees_pkg::ST_RDATA;
						end else begin
							state_reg <= sees_pkg::ST_WAIT;
						end
					end
				end
				default: begin
					drive_reg <= 1'b0;
					state_reg <= sees_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Never drives high; the pull-up makes the one
	assign sda_o = 1'b0;
	assign sda_oe_b_o = ~drive_reg;

	// ********************************************************
	// Address counter
	// ********************************************************
	always_comb begin
		addr_inc = cur_addr_reg + 9'h001;
		if (!MEM_512) begin
			addr_inc[AW-1] = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cur_addr_reg <= sees_pkg::ADDR_RESET;
		end else if (state_reg == sees_pkg::ST_DEV && ev.fall
			&& bit_cnt_reg == sees_pkg::BYTE_BITS && dev_match
			&& MEM_512) begin
			cur_addr_reg[AW-1] <= shift_reg[sees_pkg::DEVW_SEL0];
		end else if (maddr_done) begin
			cur_addr_reg[7:0] <= shift_reg;
		end else if (byte_wr) begin
			cur_addr_reg[2:0] <= cur_addr_reg[2:0] + 3'h1;
		end else if (rd_byte_done) begin
			cur_addr_reg <= addr_inc;
		end
	end

	// ********************************************************
	// Page buffer and array
	// ********************************************************
	// A poll start while programming must not drop the latched page
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			valid_reg <= '0;
		end else if (state_reg == sees_pkg::ST_IDLE
			|| (ev.start && state_reg != sees_pkg::ST_PROG)) begin
			valid_reg <= '0;
		end else if (byte_wr) begin
			// Wrapped offsets overwrite the earlier byte
			page_buf[cur_addr_reg[2:0]] <= shift_reg;
			valid_reg[cur_addr_reg[2:0]] <= 1'b1;
		end
	end

	// Only latched bytes are written; the rest of the page keeps its data
	always_ff @(posedge core_clk_i) begin
		if (prog_done) begin
			for (int i = 0; i < sees_pkg::PAGE_BYTES; i++) begin
				if (valid_reg[i]) begin
					mem[{cur_addr_reg[AW-1:3], 3'(i)}] <= page_buf[i];
				end
			end
		end
	end

	// ********************************************************
	// Programming timer
	// ********************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			prog_cnt_reg <= '0;
		end else if (state_reg != sees_pkg::ST_PROG && ev.stop && commit) begin
			if (low_supply_reg) begin
				prog_cnt_reg <= PW'(PROG_CYC_LO - 1);
			end else begin
				prog_cnt_reg <= PW'(PROG_CYC_HI - 1);
			end
		end else if (state_reg == sees_pkg::ST_PROG && prog_cnt_reg != '0) begin
			prog_cnt_reg <= prog_cnt_reg - PW'(1);
		end
	end

	// ********************************************************
	// AXI4-Lite slave
	// ********************************************************
	function automatic logic [1:0] reg_select(
		input logic [sees_pkg::AXI_ADDR_W-1:0] a);
		if (a == sees_pkg::REG_CTRL_OFS) begin
			return sees_pkg::SEL_CTRL;
		end else if (a == sees_pkg::REG_STATUS_OFS) begin
			return sees_pkg::SEL_STATUS;
		end else begin
			return sees_pkg::SEL_NONE;
		end
	endfunction

	assign s_axi_awready_o = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready_o = !w_got_reg && !bvalid_reg;
	assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= sees_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata_i;
				wstrb0_reg <= s_axi_wstrb_i[0];
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				if (reg_select(awaddr_reg) == sees_pkg::SEL_NONE) begin
					bresp_reg <= sees_pkg::RESP_SLVERR;
				end else begin
					bresp_reg <= sees_pkg::RESP_OKAY;
				end
			end else if (bvalid_reg && s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Supply range selects which programming time is used
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			low_supply_reg <= sees_pkg::CTRL_LOW_SUPPLY_RESET;
		end else if (wr_fire && wstrb0_reg
			&& reg_select(awaddr_reg) == sees_pkg::SEL_CTRL) begin
			low_supply_reg <= wdata_reg[sees_pkg::CTRL_LOW_SUPPLY_BIT];
		end
	end

	always_comb begin
		status_word = '0;
		status_word[sees_pkg::STAT_BUSY_BIT] = (state_reg == sees_pkg::ST_PROG);
		status_word[sees_pkg::STAT_WP_BIT] = pin_sync_reg.wp;
		status_word[sees_pkg::STAT_STATE_LSB +: 4] = state_reg;
		status_word[sees_pkg::STAT_ADDR_LSB +: AW] = cur_addr_reg;
	end

	assign s_axi_arready_o = !rvalid_reg;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= sees_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= sees_pkg::RESP_OKAY;
			unique case (reg_select(s_axi_araddr_i))
				sees_pkg::SEL_CTRL: begin
					rdata_reg <= 32'(low_supply_reg);
				end
				sees_pkg::SEL_STATUS: begin
					rdata_reg <= status_word;
				end
				default: begin
					rdata_reg <= '0;
					rresp_reg <= sees_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;

endmodule

// ===== inc/sees_pkg.sv
package sees_pkg;

	// ********************************************************
	// Clock and programming time
	// ********************************************************
	localparam int CLK_HZ = 40000000;
	localparam int PROG_TIME_HI_MS = 10;
	localparam int PROG_TIME_LO_MS = 15;
	// Longest times, so rounded down
	localparam int PROG_CYC_HI = PROG_TIME_HI_MS * (CLK_HZ / 1000);
	localparam int PROG_CYC_LO = PROG_TIME_LO_MS * (CLK_HZ / 1000);
	localparam int PROG_CNT_W = 20;

	// ********************************************************
	// Serial word layout
	// ********************************************************
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_OUT_BIT = 4'h7;
	localparam int DEVW_TYPE_LSB = 4;
	localparam int DEVW_SEL2 = 3;
	localparam int DEVW_SEL1 = 2;
	localparam int DEVW_SEL0 = 1;
	localparam int DEVW_DIR = 0;
	localparam logic DIR_READ = 1'h1;
	// Arbitrary neutral device-type code
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

	// ********************************************************
	// Memory organisation
	// ********************************************************
	localparam int PAGE_BYTES = 8;
	localparam int MEM_WORDS = 512;
	localparam int ADDR_W = 9;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam int AXI_ADDR_W = 12;
	localparam logic [AXI_ADDR_W-1:0] REG_CTRL_OFS = 12'h000;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS_OFS = 12'h004;
	localparam int CTRL_LOW_SUPPLY_BIT = 0;
	localparam logic CTRL_LOW_SUPPLY_RESET = 1'h0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WP_BIT = 1;
	localparam int STAT_STATE_LSB = 8;
	localparam int STAT_ADDR_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_NONE = 2'h2;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] sel;
	} sees_pins_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} sees_bus_ev_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DEV = 4'h1,
		ST_DEV_ACK = 4'h3,
		ST_MADDR = 4'h2,
		ST_MADDR_ACK = 4'h6,
		ST_WDATA = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA = 4'h4,
		ST_RACK = 4'hc,
		ST_PROG = 4'hd,
		ST_WAIT = 4'hf
	} sees_state_t;

endpackage

// ===== dv/sees_asserts.sv
`timescale 1ns/1ps
module sees_asserts (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_b_o,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ********************************
	// Serial pin
	// ********************************
	// Three high samples leave room for the pin synchronisers
	sequence scl_held;
		scl_i [*3];
	endsequence
	sequence drive_hold;
		!sda_oe_b_o [*6];
	endsequence
	sda_low_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	out_hold_a: assert property (scl_held |-> $stable(sda_oe_b_o))
		else $error("data pin moved while clock high");
	ack_hold_a: assert property ($fell(sda_oe_b_o) |-> drive_hold)
		else $error("low level released too early");
	// ********************************
	// Register bus
	// ********************************
	r_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o)
		else $error("read answer late");
	b_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
		else $error("write answer late");
	aw_block_a: assert property (s_axi_bvalid_o
		|-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer pending");
	err_zero_a: assert property (s_axi_rvalid_o
		&& s_axi_rresp_o == sees_pkg::RESP_SLVERR |-> s_axi_rdata_o == 32'h0)
		else $error("refused read carries data");
endmodule
bind sees_slave sees_asserts u_chk (.core_clk_i, .rst_b_i, .scl_i, .sda_o,
	.sda_oe_b_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o);

// ===== dv/sees_master.sv
`timescale 1ns/1ps
// ********************************
// Bus master: one bit is 8 core cycles
// ********************************
module sees_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_b_o
);
	initial begin
		scl_o = 1'b1;
		sda_oe_b_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Low 5, high 3; clock stays high between frames
	task automatic put(input logic b, output logic s);
		scl_o <= 1'b0;
		wt(3);
		sda_oe_b_o <= b;
		wt(2);
		scl_o <= 1'b1;
		wt(1);
		@(negedge clk_i);
		s = sda_i;
		wt(2);
	endtask
	task automatic edge_cond(input logic v);
		scl_o <= 1'b0;
		wt(3);
		sda_oe_b_o <= ~v;
		wt(2);
		scl_o <= 1'b1;
		wt(4);
		sda_oe_b_o <= v;
		wt(4);
	endtask
	task automatic start();
		edge_cond(1'b0);
	endtask
	task automatic stop();
		edge_cond(1'b1);
	endtask
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) put(b[i], s);
		put(1'b1, ack);
	endtask
	task automatic byte_in(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) put(1'b1, b[i]);
		put(mack, s);
	endtask
endmodule

// ===== dv/sees_slave_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sees_slave_test;
	localparam int P_HI = 200;
	localparam int P_LO = 300;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp = 1'b0;
	logic [11:0] awa = 12'h000;
	logic [11:0] ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'hf;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic awr, wr, bv, arr, rv, doe, dsda;
	logic [1:0] br, rr, r;
	logic [31:0] rd, d;
	logic [7:0] q;
	logic [7:0] mem [512];
	logic [7:0] mk [3] = '{8'h80, 8'h08, 8'h04};
	logic k;
	int n_mismatch = 0, comparisons = 0, cyc = 0, t0 = 0;
	wire mscl, moe;
	// Pull-up: high unless someone pulls low
	wire sda = (doe | dsda) & moe;

	initial forever #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	sees_slave #(.PROG_CYC_HI(P_HI), .PROG_CYC_LO(P_LO)) dut (
		.core_clk_i(clk), .rst_b_i(rst_b), .scl_i(mscl), .sda_i(sda),
		.sda_o(dsda), .sda_oe_b_o(doe), .select_pin_0_i(1'b1),
		.select_pin_1_i(1'b0), .select_pin_2_i(1'b1),
		.write_protect_i(wp), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre));
	sees_master m (.clk_i(clk), .sda_i(sda), .scl_o(mscl), .sda_oe_b_o(moe));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	// Sample at the falling edge, act just after the rising edge
	task automatic axi(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		logic sa, sw, sr, sb;
		int i;
		@(posedge clk);
		if (w) begin
			awa <= a;
			wd <= v;
			awv <= 1'b1;
			wv <= 1'b1;
			bre <= 1'b1;
		end else begin
			ara <= a;
			arv <= 1'b1;
			rre <= 1'b1;
		end
		for (i = 0; i < 20; i++) begin
			@(negedge clk);
			sa = awv & awr;
			sw = wv & wr;
			sr = arv & arr;
			sb = (bv & bre) | (rv & rre);
			d = rd;
			r = w ? br : rr;
			@(posedge clk);
			if (sa) awv <= 1'b0;
			if (sw) wv <= 1'b0;
			if (sr) arv <= 1'b0;
			if (sb) begin
				bre <= 1'b0;
				rre <= 1'b0;
				break;
			end
		end
		if (i == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	task automatic stat();
		axi(1'b0, sees_pkg::REG_STATUS_OFS, 32'h0);
	endtask
	task automatic wait_to(input int n);
		while (cyc < t0 + n) @(posedge clk);
	endtask
	function automatic logic [7:0] dw(input logic dir, input logic a8);
		return {sees_pkg::DEV_TYPE_DEFAULT, 1'b1, 1'b0, a8, dir};
	endfunction
	task automatic addr_phase(input logic [8:0] a);
		m.start();
		m.byte_out(dw(1'b0, a[8]), k);
		`CHK("dev ack", 1'b0, k)
		m.byte_out(a[7:0], k);
		`CHK("addr ack", 1'b0, k)
	endtask
	task automatic wr_seq(input logic [8:0] a, input int n, input logic [7:0] b);
		addr_phase(a);
		for (int i = 0; i < n; i++) begin
			m.byte_out(8'(b + i), k);
			`CHK("data ack", 1'b0, k)
			if (!wp) mem[{a[8:3], 3'(a[2:0] + i)}] = 8'(b + i);
		end
		m.stop();
		t0 = cyc;
	endtask
	task automatic rd_seq(input logic [8:0] a, input int n);
		addr_phase(a);
		m.start();
		m.byte_out(dw(1'b1, a[8]), k);
		`CHK("read ack", 1'b0, k)
		for (int i = 0; i < n; i++) begin
			m.byte_in(i == n - 1, q);
			`CHK("rdata", mem[9'(a + i)], q)
		end
		m.byte_in(1'b1, q);
		`CHK("released", 8'hff, q)
		m.stop();
		stat();
		`CHK("state", sees_pkg::ST_IDLE, d[11:8])
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		axi(1'b0, sees_pkg::REG_CTRL_OFS, 32'h0);
		`CHK("ctrl reset", 32'h0, d)
		axi(1'b1, sees_pkg::REG_CTRL_OFS, 32'h1);
		`CHK("ctrl bresp", sees_pkg::RESP_OKAY, r)
		axi(1'b0, sees_pkg::REG_CTRL_OFS, 32'h0);
		`CHK("ctrl", 32'h1, d)
		// Cleared low strobe: write is answered but leaves the bit alone
		ws <= 4'h0;
		axi(1'b1, sees_pkg::REG_CTRL_OFS, 32'h0);
		`CHK("no strobe bresp", sees_pkg::RESP_OKAY, r)
		axi(1'b0, sees_pkg::REG_CTRL_OFS, 32'h0);
		`CHK("no strobe ctrl", 32'h1, d)
		ws <= 4'hf;
		axi(1'b1, 12'h008, 32'h1);
		`CHK("hole bresp", sees_pkg::RESP_SLVERR, r)
		axi(1'b0, 12'h008, 32'h0);
		`CHK("hole rresp", sees_pkg::RESP_SLVERR, r)
		axi(1'b1, sees_pkg::REG_CTRL_OFS, 32'h0);
		note("registers");
		foreach (mk[j]) begin
			m.start();
			m.byte_out(dw(1'b0, 1'b0) ^ mk[j], k);
			`CHK("mismatch nack", 1'b1, k)
			m.stop();
		end
		note("addressing");
		// Ten bytes from offset 6: wraps, last two overwrite
		wr_seq(9'h10e, 10, 8'h10);
		m.start();
		m.byte_out(dw(1'b0, 1'b0), k);
		`CHK("busy poll", 1'b1, k)
		m.stop();
		wait_to(P_HI + 12);
		stat();
		`CHK("busy", 1'b0, d[sees_pkg::STAT_BUSY_BIT])
		m.start();
		m.byte_out(dw(1'b0, 1'b0), k);
		`CHK("done poll", 1'b0, k)
		m.stop();
		note("page write");
		axi(1'b1, sees_pkg::REG_CTRL_OFS, 32'h1);
		wr_seq(9'h00e, 1, 8'h5a);
		wait_to(P_HI + 12);
		stat();
		`CHK("busy", 1'b1, d[sees_pkg::STAT_BUSY_BIT])
		wait_to(P_LO + 12);
		stat();
		`CHK("busy", 1'b0, d[sees_pkg::STAT_BUSY_BIT])
		axi(1'b1, sees_pkg::REG_CTRL_OFS, 32'h0);
		note("byte write");
		wp <= 1'b1;
		wr_seq(9'h10e, 1, 8'haa);
		repeat (10) @(posedge clk);
		stat();
		`CHK("busy", 1'b0, d[sees_pkg::STAT_BUSY_BIT])
		`CHK("wp", 1'b1, d[sees_pkg::STAT_WP_BIT])
		rd_seq(9'h108, 8);
		wp <= 1'b0;
		rd_seq(9'h00e, 1);
		note("protect and read");
		tally_and_finish();
	end
endmodule
